// *** logic/drive_stop_status.sv ***
`timescale 1ns/1ps
// Functional notes
// RL1: Interpolated position mode bit 10 shows target reached, or stopped while halt is set.
// RL2: Interpolated position mode bit 12 shows the interpolation flag and bit 13 reads zero.
// RL3: Profile velocity mode bit 10 shows goal speed reached, or stopped while halt is set.
// RL4: Profile velocity mode bit 12 shows zero speed and bit 13 reads zero.
// RL5: Profile torque mode bit 10 shows goal torque reached or stopped, bits 12 and 13 read zero.
// RL6: A quick stop follows its option code 0 to 4, default 2, always ending switch-on-disabled.
// RL7: In torque modes quick stop, shutdown and disable operation always remove servo power.
// RL8: Shutdown follows its option code 0 to 1, default 0, ending switch-on-disabled.
// RL9: Disable operation follows its option code 0 to 1, default 1, then disables.
// RL10: Normal stop rate is the profile object, or the homing object in homing mode.
// RL11: Quick-stop rate selection uses the dedicated quick-stop deceleration object.
// RL12: A set halt bit applies the halt option code 0 to 4, default 1.
// RL13: Halt codes 1, 2 and 3 pick normal, quick-stop or torque-limit rate and stay enabled.
// RL14: Halt in a torque mode ramps the torque reference to zero.
// RL15: Bits 10, 12 and 13 follow the active mode and update with the rest of the word.
module drive_stop_status
  import drive_stop_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [15:0]       controlword,
  input  wire logic [15:0]       statusword_in,
  input  wire logic [7:0]        mode,
  input  wire logic              target_reached,
  input  wire logic              axis_stopped,
  input  wire logic              interpolation_on_flag,
  input  wire logic              speed_zero,
  input  wire logic              quick_stop_req,
  input  wire logic              shutdown_req,
  input  wire logic              disable_op_req,
  output logic      [15:0]       statusword,
  output rate_t                  decel_rate,
  output logic                   servo_off,
  output end_t                   end_state,
  output logic                   torque_ramp,
  output logic                   irq
);
  logic [IDX_W-1:0] idx;
  logic             setup;
  logic             wr_done;
  logic             hit_err;
  logic [31:0]      rd_val;
  logic [31:0]      prdata_d;
  logic             pready_d;
  logic             pslverr_d;
  logic [15:0]      opt_quick;
  logic [15:0]      opt_shut;
  logic [15:0]      opt_disop;
  logic [15:0]      opt_halt;
  logic             off_quick;
  logic             off_shut;
  logic             off_disop;
  rate_t            rate_quick;
  rate_t            rate_shut;
  rate_t            rate_disop;
  rate_t            rate_halt;
  logic             halt;
  logic             torque_mode;
  logic             take_new;
  seq_t             seq_q;
  seq_t             seq_d;
  kind_t            kind_q;
  kind_t            kind_d;
  rate_t            rate_d;
  end_t             end_d;
  logic [EV_W-1:0]  ev_set;
  logic [EV_W-1:0]  evstat_q;
  logic [EV_W-1:0]  evstat_d;
  logic [EV_W-1:0]  evmask_q;
  logic [EV_W-1:0]  evmask_d;
  logic [15:0]      sw_d;

  assign idx         = paddr[ADDR_W-1:2];
  assign setup       = psel && !penable;
  assign wr_done     = psel && penable && pready && pwrite && !pslverr;
  assign halt        = controlword[CW_HALT];
  assign torque_mode = (mode == MODE_PT) || (mode == MODE_CST);

  option_reg #(.RESET_VAL(RST_QUICK)) u_quick (
    .pclk(pclk), .presetn(presetn), .value_q(opt_quick),
    .we(wr_done && idx == IDX_QUICK), .wdata(pwdata[15:0]));
  option_reg #(.RESET_VAL(RST_SHUT)) u_shut (
    .pclk(pclk), .presetn(presetn), .value_q(opt_shut),
    .we(wr_done && idx == IDX_SHUT), .wdata(pwdata[15:0]));
  option_reg #(.RESET_VAL(RST_DISOP)) u_disop (
    .pclk(pclk), .presetn(presetn), .value_q(opt_disop),
    .we(wr_done && idx == IDX_DISOP), .wdata(pwdata[15:0]));
  option_reg #(.RESET_VAL(RST_HALT)) u_halt (
    .pclk(pclk), .presetn(presetn), .value_q(opt_halt),
    .we(wr_done && idx == IDX_HALT), .wdata(pwdata[15:0]));

  stop_decode #(.MAX_CODE(MAX_QUICK), .IS_HALT(1'b0)) u_dq (
    .code(opt_quick), .mode(mode), .servo_off(off_quick), .rate(rate_quick));
  stop_decode #(.MAX_CODE(MAX_SHUT), .IS_HALT(1'b0)) u_ds (
    .code(opt_shut), .mode(mode), .servo_off(off_shut), .rate(rate_shut));
  stop_decode #(.MAX_CODE(MAX_DISOP), .IS_HALT(1'b0)) u_dd (
    .code(opt_disop), .mode(mode), .servo_off(off_disop), .rate(rate_disop));
  stop_decode #(.MAX_CODE(MAX_HALT), .IS_HALT(1'b1)) u_dh (
    .code(opt_halt), .mode(mode), .servo_off(), .rate(rate_halt));

  // Answer is prepared in the setup cycle so every bus output is a flop.
  always_comb begin
    rd_val  = 32'h0000_0000;
    hit_err = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      hit_err = 1'b1;
    end else if (idx == IDX_QUICK) begin
      rd_val[15:0] = opt_quick;
    end else if (idx == IDX_SHUT) begin
      rd_val[15:0] = opt_shut;
    end else if (idx == IDX_DISOP) begin
      rd_val[15:0] = opt_disop;
    end else if (idx == IDX_HALT) begin
      rd_val[15:0] = opt_halt;
    end else if (idx == IDX_EVSTAT) begin
      rd_val[EV_W-1:0] = evstat_q;
    end else if (idx == IDX_EVMASK) begin
      rd_val[EV_W-1:0] = evmask_q;
    end else if (idx == IDX_SEQ && !pwrite) begin
      rd_val[9:0] = {kind_q, end_state, 1'b0, decel_rate, seq_q};
    end else begin
      hit_err = 1'b1;
    end
    pready_d  = setup;
    pslverr_d = setup && hit_err;
    prdata_d  = (setup && !pwrite && !hit_err) ? rd_val : 32'h0000_0000;
  end

  // Requests from the drive state machine beat a halt in progress.
  always_comb begin
    take_new = (seq_q == SEQ_IDLE || kind_q == KIND_HALT)
               && (quick_stop_req || shutdown_req || disable_op_req);
    seq_d    = seq_q;
    kind_d   = kind_q;
    rate_d   = decel_rate;
    end_d    = end_state;
    ev_set   = '0;
    if (take_new) begin
      if (quick_stop_req) begin
        kind_d = KIND_QUICK; // [RL6]
        end_d  = END_SOD;
        rate_d = rate_quick;
        seq_d  = off_quick ? SEQ_DONE : SEQ_DECEL;
      end else if (shutdown_req) begin
        kind_d = KIND_SHUT; // [RL8]
        end_d  = END_SOD;
        rate_d = rate_shut;
        seq_d  = off_shut ? SEQ_DONE : SEQ_DECEL;
      end else begin
        kind_d = KIND_DISOP; // [RL9]
        end_d  = END_SON;
        rate_d = rate_disop;
        seq_d  = off_disop ? SEQ_DONE : SEQ_DECEL;
      end
      if (seq_d == SEQ_DONE) begin
        rate_d = RATE_NONE;
      end
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          if (halt) begin
            kind_d = KIND_HALT; // [RL12]
            end_d  = END_OPEN; // [RL13]
            rate_d = rate_halt;
            seq_d  = SEQ_DECEL;
          end
        end
        SEQ_DECEL: begin
          if (kind_q == KIND_HALT && !halt) begin
            rate_d = RATE_NONE;
            seq_d  = SEQ_IDLE;
          end else if (axis_stopped) begin
            rate_d = RATE_NONE;
            seq_d  = (kind_q == KIND_HALT) ? SEQ_HALTED : SEQ_DONE; // [RL13]
          end
        end
        SEQ_HALTED: begin
          if (!halt) begin
            seq_d = SEQ_IDLE;
          end
        end
        default: begin
          seq_d = SEQ_IDLE;
        end
      endcase
    end
    if (seq_d == SEQ_DONE) begin
      ev_set[kind_d] = 1'b1;
    end
    if (seq_d == SEQ_HALTED && seq_q != SEQ_HALTED) begin
      ev_set[EV_HALT] = 1'b1;
    end
  end

  // A set in the same cycle as a write-one-to-clear wins.
  always_comb begin
    evstat_d = evstat_q;
    evmask_d = evmask_q;
    if (wr_done && idx == IDX_EVSTAT) begin
      evstat_d = evstat_q & ~pwdata[EV_W-1:0];
    end
    if (wr_done && idx == IDX_EVMASK) begin
      evmask_d = pwdata[EV_W-1:0];
    end
    evstat_d = evstat_d | ev_set;
  end

  always_comb begin
    sw_d = statusword_in;
    if (mode == MODE_IP) begin
      sw_d[SW_TGT] = halt ? axis_stopped : target_reached; // [RL1] [RL15]
      sw_d[SW_B12] = interpolation_on_flag; // [RL2]
      sw_d[SW_B13] = 1'b0; // [RL2]
    end else if (mode == MODE_PV) begin
      sw_d[SW_TGT] = halt ? axis_stopped : target_reached; // [RL3]
      sw_d[SW_B12] = speed_zero; // [RL4]
      sw_d[SW_B13] = 1'b0; // [RL4]
    end else if (mode == MODE_PT) begin
      sw_d[SW_TGT] = halt ? axis_stopped : target_reached; // [RL5]
      sw_d[SW_B12] = 1'b0; // [RL5]
      sw_d[SW_B13] = 1'b0; // [RL5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      seq_q       <= SEQ_IDLE;
      kind_q      <= KIND_QUICK;
      decel_rate  <= RATE_NONE;
      end_state   <= END_NONE;
      servo_off   <= 1'b0;
      torque_ramp <= 1'b0;
      evstat_q    <= '0;
      evmask_q    <= EVMASK_RST;
      irq         <= 1'b0;
      statusword  <= 16'h0000;
    end else begin
      prdata      <= prdata_d;
      pready      <= pready_d;
      pslverr     <= pslverr_d;
      seq_q       <= seq_d;
      kind_q      <= kind_d;
      decel_rate  <= rate_d;
      end_state   <= end_d;
      servo_off   <= (seq_d == SEQ_DONE); // [RL7]
      torque_ramp <= halt && torque_mode; // [RL14]
      evstat_q    <= evstat_d;
      evmask_q    <= evmask_d;
      irq         <= |(evstat_d & evmask_d);
      statusword  <= sw_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ip_bit12_a: assert property ($past(mode) == MODE_IP |->  // [RL2]
    statusword[SW_B12] == $past(interpolation_on_flag) && !statusword[SW_B13])
    else $error("ip bit 12 or 13 wrong");
  pv_bit12_a: assert property ($past(mode) == MODE_PV |->  // [RL4]
    statusword[SW_B12] == $past(speed_zero)) else $error("pv bit 12 wrong");
  halt_tgt_a: assert property ($past(mode) == MODE_PT && $past(halt) |->  // [RL5]
    statusword[SW_TGT] == $past(axis_stopped)) else $error("pt bit 10 wrong");
  torque_off_a: assert property (seq_q == SEQ_IDLE && quick_stop_req && torque_mode  // [RL7]
    |=> seq_q == SEQ_DONE ##1 seq_q == SEQ_IDLE) else $error("torque stop not off");
  quick_rate_a: assert property (seq_q == SEQ_IDLE && quick_stop_req && !torque_mode  // [RL11]
    && opt_quick == OPT_DEC_QS |=> decel_rate == RATE_QUICK && end_state == END_SOD)
    else $error("quick rate wrong");
  homing_rate_a: assert property (seq_q == SEQ_IDLE && !quick_stop_req && shutdown_req  // [RL10]
    && mode == MODE_HM && opt_shut == OPT_DEC_NRM |=> decel_rate == RATE_HOMING)
    else $error("homing rate wrong");
  halt_stay_a: assert property (seq_q == SEQ_DECEL && kind_q == KIND_HALT && halt  // [RL13]
    && axis_stopped && !take_new |=> seq_q == SEQ_HALTED && end_state == END_OPEN)
    else $error("halt left enabled");
  ramp_a: assert property ((halt && torque_mode) [*2] |=> torque_ramp)  // [RL14]
    else $error("torque ramp missing");
  disop_end_a: assert property (seq_q == SEQ_IDLE && disable_op_req && !quick_stop_req  // [RL9]
    && !shutdown_req |=> end_state == END_SON) else $error("disable end wrong");
  shut_end_a: assert property (seq_q == SEQ_IDLE && shutdown_req && !quick_stop_req  // [RL8]
    |=> end_state == END_SOD) else $error("shutdown end wrong");
  halt_take_a: assert property (seq_q == SEQ_IDLE && halt && !quick_stop_req  // [RL12]
    && !shutdown_req && !disable_op_req |=> kind_q == KIND_HALT && end_state == END_OPEN)
    else $error("halt not taken");

  halt_cov: cover property (seq_q == SEQ_DECEL ##[1:50] seq_q == SEQ_HALTED);
  decel_cov: cover property (seq_q == SEQ_DECEL ##[1:50] seq_q == SEQ_DONE);
  irq_cov: cover property ($rose(irq));
  ramp_cov: cover property ($rose(torque_ramp));
  release_cov: cover property (seq_q == SEQ_HALTED ##1 seq_q == SEQ_IDLE);
endmodule

// *** logic/drive_stop_pkg.sv ***
package drive_stop_pkg;
  localparam int          ADDR_W      = 20;
  localparam int          IDX_W       = 18;
  // Register indices; the byte address is four times the index.
  localparam logic [17:0] IDX_QUICK   = 18'h0605a;
  localparam logic [17:0] IDX_SHUT    = 18'h0605b;
  localparam logic [17:0] IDX_DISOP   = 18'h0605c;
  localparam logic [17:0] IDX_HALT    = 18'h0605d;
  localparam logic [17:0] IDX_EVSTAT  = 18'h06100;
  localparam logic [17:0] IDX_EVMASK  = 18'h06101;
  localparam logic [17:0] IDX_SEQ     = 18'h06102;
  localparam logic [15:0] RST_QUICK   = 16'h0002;
  localparam logic [15:0] RST_SHUT    = 16'h0000;
  localparam logic [15:0] RST_DISOP   = 16'h0001;
  localparam logic [15:0] RST_HALT    = 16'h0001;
  localparam logic [15:0] MAX_QUICK   = 16'h0004;
  localparam logic [15:0] MAX_SHUT    = 16'h0001;
  localparam logic [15:0] MAX_DISOP   = 16'h0001;
  localparam logic [15:0] MAX_HALT    = 16'h0004;
  localparam logic [15:0] OPT_OFF     = 16'h0000;
  localparam logic [15:0] OPT_DEC_NRM = 16'h0001;
  localparam logic [15:0] OPT_DEC_QS  = 16'h0002;
  localparam logic [15:0] OPT_DEC_TL  = 16'h0003;
  localparam logic [7:0]  MODE_PV     = 8'h03;
  localparam logic [7:0]  MODE_PT     = 8'h04;
  localparam logic [7:0]  MODE_HM     = 8'h06;
  localparam logic [7:0]  MODE_IP     = 8'h07;
  localparam logic [7:0]  MODE_CST    = 8'h0a;
  localparam int          CW_HALT     = 8;
  localparam int          SW_TGT      = 10;
  localparam int          SW_B12      = 12;
  localparam int          SW_B13      = 13;
  localparam int          EV_W        = 4;
  localparam int          EV_QUICK    = 0;
  localparam int          EV_SHUT     = 1;
  localparam int          EV_DISOP    = 2;
  localparam int          EV_HALT     = 3;
  localparam logic [3:0]  EVMASK_RST  = 4'h0;
  typedef enum logic [2:0] {
    RATE_NONE, RATE_PROFILE, RATE_HOMING, RATE_QUICK, RATE_TLIM
  } rate_t;
  typedef enum logic [1:0] {END_NONE, END_SOD, END_SON, END_OPEN} end_t;
  typedef enum logic [1:0] {KIND_QUICK, KIND_SHUT, KIND_DISOP, KIND_HALT} kind_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00, SEQ_DECEL = 2'b01, SEQ_DONE = 2'b11, SEQ_HALTED = 2'b10
  } seq_t;
endpackage

// *** logic/option_reg.sv ***
`timescale 1ns/1ps
module option_reg
  import drive_stop_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        we,
  input  wire logic [15:0] wdata,
  output logic      [15:0] value_q
);
  logic [15:0] value_d;

  always_comb begin
    value_d = we ? wdata : value_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end
endmodule

// *** logic/stop_decode.sv ***
`timescale 1ns/1ps
module stop_decode
  import drive_stop_pkg::*;
#(
  parameter logic [15:0] MAX_CODE = 16'h0001,
  parameter bit          IS_HALT  = 1'b0
) (
  input  wire logic [15:0] code,
  input  wire logic [7:0]  mode,
  output logic             servo_off,
  output rate_t            rate
);
  logic torque;
  logic homing;

  always_comb begin
    torque    = (mode == MODE_PT) || (mode == MODE_CST);
    homing    = (mode == MODE_HM);
    servo_off = 1'b0;
    rate      = homing ? RATE_HOMING : RATE_PROFILE; // [RL10]
    if (!IS_HALT && torque) begin
      servo_off = 1'b1; // [RL7]
      rate      = RATE_NONE;
    end else if (code > MAX_CODE) begin
      // Out-of-range codes fall back to the safest reaction of each kind.
      servo_off = !IS_HALT;
      if (!IS_HALT) begin
        rate = RATE_NONE;
      end
    end else if (code == OPT_OFF) begin
      // A halt must stay in operation enabled, so code 0 decelerates.
      servo_off = !IS_HALT;
      if (!IS_HALT) begin
        rate = RATE_NONE;
      end
    end else if (code == OPT_DEC_QS) begin
      rate = RATE_QUICK; // [RL11]
    end else if (code == OPT_DEC_TL) begin
      rate = RATE_TLIM;
    end
  end
endmodule

// *** tb/motion_ctrl_model.sv ***
`timescale 1ns/1ps
module motion_ctrl_model
  import drive_stop_pkg::*;
(
  input  wire logic        pclk,
  output logic      [15:0] controlword,
  output logic      [7:0]  mode
);
  initial begin
    controlword = 16'h0000;
    mode        = MODE_IP;
  end
  // The controller changes its command only just after an edge, so a same-edge race is avoided.
  task automatic command(input logic halt, input logic [7:0] m);
    @(posedge pclk);
    controlword <= {7'h00, halt, 8'h0f};
    mode        <= m;
  endtask
endmodule

// *** tb/tb_drive_stop_option_status_logic.sv ***
`timescale 1ns/1ps
module tb_drive_stop_option_status_logic;
  import drive_stop_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [15:0]       statusword_in = '0;
  logic              target_reached = 1'b0;
  logic              axis_stopped = 1'b0;
  logic              interpolation_on_flag = 1'b0;
  logic              speed_zero = 1'b0;
  logic              quick_stop_req = 1'b0;
  logic              shutdown_req = 1'b0;
  logic              disable_op_req = 1'b0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [15:0]       controlword;
  logic [15:0]       statusword;
  logic [7:0]        mode;
  rate_t             decel_rate;
  end_t              end_state;
  logic              servo_off;
  logic              torque_ramp;
  logic              irq;
  logic [31:0]       rd;
  logic              er;
  int                errors = 0;
  int                checks = 0;
  rate_t             qrate [5] = '{RATE_NONE, RATE_PROFILE, RATE_QUICK, RATE_TLIM, RATE_PROFILE};
  logic [7:0]        modes [4] = '{MODE_IP, MODE_PV, MODE_PT, MODE_HM};
  logic [15:0]       sw_exp [8] = '{16'hcfff, 16'hdfff, 16'hcfff, 16'hffff,
                                    16'h1000, 16'h0000, 16'h0000, 16'h0000};

  always #20 pclk = ~pclk;

  motion_ctrl_model u_ctrl (.pclk(pclk), .controlword(controlword), .mode(mode));

  drive_stop_status u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .controlword, .statusword_in, .mode, .target_reached, .axis_stopped,
    .interpolation_on_flag, .speed_zero, .quick_stop_req, .shutdown_req, .disable_op_req,
    .statusword, .decel_rate, .servo_off, .end_state, .torque_ramp, .irq
  );

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Waits for pready without assuming the slave's latency; a hang ends the run.
  task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stop_req(input int k);
    @(posedge pclk);
    quick_stop_req <= (k == 0);
    shutdown_req   <= (k == 1);
    disable_op_req <= (k == 2);
    @(posedge pclk);
    quick_stop_req <= 1'b0;
    shutdown_req   <= 1'b0;
    disable_op_req <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic settle();
    int n;
    n = 0;
    @(posedge pclk);
    axis_stopped <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (servo_off !== 1'b1 && n < 10);
    if (n >= 10) begin
      errors++;
      stop_test();
    end
    chk("rate after stop", 32'(decel_rate), 32'(RATE_NONE));
    @(posedge pclk);
    axis_stopped <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_QUICK, '0);
    chk("quick reset", rd, 32'h2);
    apb(1'b0, IDX_SHUT, '0);
    chk("shutdown reset", rd, 32'h0);
    apb(1'b0, IDX_DISOP, '0);
    chk("disable reset", rd, 32'h1);
    apb(1'b0, IDX_HALT, '0);
    chk("halt reset", rd, 32'h1);
    apb(1'b1, 18'h00001, 32'h5);
    chk("unmapped error", 32'(er), 32'h1);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      u_ctrl.command(1'b0, modes[i%4]);
      statusword_in         <= (i < 4) ? 16'hffff : 16'h0000;
      target_reached        <= (i < 4);
      interpolation_on_flag <= (i >= 4);
      speed_zero            <= (i < 4);
      @(posedge pclk);
      @(negedge pclk);
      chk("status word", 32'(statusword), 32'(sw_exp[i]));
    end
    $display("test status bits done");
    u_ctrl.command(1'b0, MODE_IP);
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, IDX_QUICK, 32'(c));
      stop_req(0);
      chk("quick rate", 32'(decel_rate), 32'(qrate[c]));
      chk("quick end", 32'(end_state), 32'(END_SOD));
      chk("quick off", 32'(servo_off), 32'(c == 0));
      if (c == 0) repeat (3) @(posedge pclk);
      else settle();
    end
    u_ctrl.command(1'b0, MODE_HM);
    apb(1'b1, IDX_QUICK, 32'h1);
    stop_req(0);
    chk("homing rate", 32'(decel_rate), 32'(RATE_HOMING));
    settle();
    u_ctrl.command(1'b0, MODE_IP);
    stop_req(1);
    chk("shutdown off", 32'(servo_off), 32'h1);
    repeat (3) @(posedge pclk);
    apb(1'b1, IDX_SHUT, 32'h1);
    stop_req(1);
    chk("shutdown rate", 32'(decel_rate), 32'(RATE_PROFILE));
    chk("shutdown end", 32'(end_state), 32'(END_SOD));
    settle();
    stop_req(2);
    chk("disable rate", 32'(decel_rate), 32'(RATE_PROFILE));
    chk("disable end", 32'(end_state), 32'(END_SON));
    settle();
    u_ctrl.command(1'b0, MODE_HM);
    stop_req(1);
    chk("homing shutdown rate", 32'(decel_rate), 32'(RATE_HOMING));
    settle();
    for (int k = 0; k < 6; k++) begin
      u_ctrl.command(1'b0, (k < 3) ? MODE_PT : MODE_CST);
      stop_req(k % 3);
      chk("torque off", 32'(servo_off), 32'h1);
      chk("torque rate", 32'(decel_rate), 32'(RATE_NONE));
      repeat (3) @(posedge pclk);
    end
    $display("test stop codes done");
    target_reached <= 1'b1;
    for (int h = 1; h < 4; h++) begin
      apb(1'b1, IDX_HALT, 32'(h));
      u_ctrl.command(1'b1, (h == 1) ? MODE_PT : MODE_IP);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("halt rate", 32'(decel_rate), 32'(qrate[h]));
      chk("halt end", 32'(end_state), 32'(END_OPEN));
      chk("halt ramp", 32'(torque_ramp), 32'(h == 1));
      chk("halt moving bit", 32'(statusword[SW_TGT]), 32'h0);
      @(posedge pclk);
      axis_stopped <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("halt stopped bit", 32'(statusword[SW_TGT]), 32'h1);
      u_ctrl.command(1'b0, MODE_IP);
      axis_stopped <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    $display("test halt done");
    apb(1'b1, IDX_EVSTAT, 32'hf);
    apb(1'b1, IDX_QUICK, 32'h0);
    stop_req(0);
    repeat (2) @(negedge pclk);
    chk("masked irq", 32'(irq), 32'h0);
    apb(1'b0, IDX_EVSTAT, '0);
    chk("event status", rd, 32'h1);
    apb(1'b1, IDX_EVMASK, 32'h1);
    @(negedge pclk);
    chk("irq raised", 32'(irq), 32'h1);
    apb(1'b1, IDX_EVSTAT, 32'h1);
    @(negedge pclk);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("test interrupt done");
    stop_test();
  end
endmodule
